// ===== hdl/chgsp_pkg.sv
// shared constants for the charger setpoint decoder
package chgsp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // command codes of the word writes that reach this block
    localparam logic [7:0]  CHGSP_CMD_CURRENT   = 8'h14;   // charge_current_cmd
    localparam logic [7:0]  CHGSP_CMD_VOLTAGE   = 8'h15;   // charge_voltage_cmd
    localparam logic [7:0]  CHGSP_CMD_INPUT     = 8'h3f;   // input_limit_cmd

    ////////////////////////////////////////////////////////////////////////////
    // setpoint limits, in millivolts or milliamperes (one code step each)
    localparam logic [15:0] CHGSP_V_MIN_MV      = 16'h0400; // 1.024 V floor
    localparam logic [15:0] CHGSP_V_MAX_MV      = 16'h4b00; // 19.200 V ceiling
    localparam logic [15:0] CHGSP_I_MIN_MA      = 16'h0080; // 128 mA floor
    localparam logic [15:0] CHGSP_I_MAX_MA      = 16'h1f80; // 8.064 A ceiling
    localparam logic [15:0] CHGSP_LIM_MIN_MA    = 16'h0100; // 256 mA floor
    localparam logic [15:0] CHGSP_LIM_MAX_MA    = 16'h2afc; // 11.004 A ceiling
    localparam logic [15:0] CHGSP_PRECHG_MA     = 16'h0080; // undervoltage cap

    ////////////////////////////////////////////////////////////////////////////
    // values after power-on reset
    localparam logic [15:0] CHGSP_V_RESET       = 16'h0000;
    localparam logic [15:0] CHGSP_I_RESET       = 16'h0080; // 128 mA
    localparam logic [15:0] CHGSP_LIM_RESET     = 16'h0100; // 256 mA
    localparam logic [5:0]  CHGSP_THROTTLE_FULL = 6'h3f;    // no input throttling

    ////////////////////////////////////////////////////////////////////////////
    // dac field positions inside the command words
    localparam int          CHGSP_V_LSB         = 4;
    localparam int          CHGSP_V_MSB         = 14;
    localparam int          CHGSP_I_LSB         = 7;
    localparam int          CHGSP_I_MSB         = 12;
    localparam logic [16:0] CHGSP_CEIL_GAIN     = 17'h00005; // 5 V/V and 5 A/V

    ////////////////////////////////////////////////////////////////////////////
    // flag positions in charger_flags_word
    localparam int          CHGSP_FLAG_ADAPTER  = 15;
    localparam int          CHGSP_FLAG_PACK     = 14;
    localparam int          CHGSP_FLAG_SUPFAIL  = 13;

    ////////////////////////////////////////////////////////////////////////////
    // timing of the input-limit throttle ramp
    localparam int          CHGSP_CLK_PERIOD_NS = 20;
    localparam int          CHGSP_RAMP_STEP_NS  = 10000;
    localparam int          CHGSP_RAMP_CYCLES   = CHGSP_RAMP_STEP_NS / CHGSP_CLK_PERIOD_NS;
    localparam logic [9:0]  CHGSP_RAMP_LAST     = 10'(CHGSP_RAMP_CYCLES - 1);

    // which regulation loop owns the converter
    typedef enum logic [1:0] {
        CHGSP_LOOP_OFF,
        CHGSP_LOOP_CURRENT,
        CHGSP_LOOP_VOLTAGE,
        CHGSP_LOOP_INPUT
    } chgsp_loop_t;

endpackage

// ===== hdl/chgsp_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; a bit changes once stages two and three agree
module chgsp_pin_sync
    import chgsp_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] pin_in,
    output var  logic [WIDTH-1:0] pin_out
);
    logic [WIDTH-1:0] stage1;      // metastable stage, read only by stage2
    logic [WIDTH-1:0] stage2;      // settled stage
    logic [WIDTH-1:0] stage3;      // agreement stage
    logic [WIDTH-1:0] next_out;    // filtered value

    ////////////////////////////////////////////////////////////////////////////
    // accept a bit only when the two settled stages agree, filtering runts
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_out[i] = (stage2[i] == stage3[i]) ? stage3[i] : pin_out[i];
        end
    end

    // chain and filtered output
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stage1  <= '0;
            stage2  <= '0;
            stage3  <= '0;
            pin_out <= '0;
        end else begin
            stage1  <= pin_in;
            stage2  <= stage1;
            stage3  <= stage2;
            pin_out <= next_out;
        end
    end
endmodule
`default_nettype wire

// ===== hdl/chgsp_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module chgsp_decoder
    import chgsp_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_data,
    input  wire logic        cmd_write,
    input  wire logic [11:0] voltage_ceiling_pin,
    input  wire logic [11:0] current_ceiling_pin,
    input  wire logic        adapter_above_min,
    input  wire logic        adapter_below_battery,
    input  wire logic        thermistor_input_low,
    input  wire logic        battery_below_low,
    input  wire logic        battery_above_resume,
    input  wire logic        logic_supply_low,
    input  wire logic        battery_at_setpoint,
    input  wire logic        input_over_limit,
    output var  logic [10:0] voltage_dac,
    output var  logic [5:0]  charge_current_dac,
    output var  logic [5:0]  input_limit_dac,
    output var  chgsp_loop_t active_loop,
    output var  logic        charge_enable,
    output var  logic        source_switch_drive,
    output var  logic        load_switch_drive,
    output var  logic [15:0] charger_flags_word
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // clamp a request into [lo, hi]
    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                            input logic [15:0] hi);
        logic [15:0] r;
        r = v;
        if (v > hi) begin
            r = hi;
        end else if (v < lo) begin
            r = lo;
        end
        return r;
    endfunction

    // cap a setting against a pin ceiling scaled by five
    function automatic logic [15:0] ceil_cap(input logic [15:0] v, input logic [11:0] pin);
        logic [16:0] lim;
        lim = {5'h00, pin} * CHGSP_CEIL_GAIN;
        return ({1'b0, v} > lim) ? lim[15:0] : v;
    endfunction

    // six-bit current dac field, held at full scale where the word runs past it
    function automatic logic [5:0] cur_field(input logic [15:0] v);
        return (v[15:CHGSP_I_MSB+1] != 3'h0) ? 6'h3f : v[CHGSP_I_MSB:CHGSP_I_LSB];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: all analog comparator and ceiling inputs are foreign
    logic [11:0] vceil_s;      // voltage ceiling pin, millivolts
    logic [11:0] iceil_s;      // current ceiling pin, millivolts
    logic [7:0]  cmp_s;        // comparator levels
    logic        ac_ok;        // adapter above 7.5 V
    logic        pfail_cmp;    // adapter below battery plus 0.3 V
    logic        pack_cmp;     // thermistor below 91 % of logic supply
    logic        battery_sense_input_low_cmp; // battery under 2.5 V
    logic        battery_sense_input_ok_cmp;  // battery above 2.7 V
    logic        vdd_low;      // logic supply under 2.5 V
    logic        at_setpoint;  // battery reached voltage setpoint
    logic        over_limit;   // total input current over limit

    chgsp_pin_sync #(.WIDTH(24)) u_ceil_sync (
        .clock   (clock),
        .rst     (rst),
        .pin_in  ({voltage_ceiling_pin, current_ceiling_pin}),
        .pin_out ({vceil_s, iceil_s})
    );

    chgsp_pin_sync #(.WIDTH(8)) u_cmp_sync (
        .clock   (clock),
        .rst     (rst),
        .pin_in  ({adapter_above_min, adapter_below_battery, thermistor_input_low,
                   battery_below_low, battery_above_resume, logic_supply_low,
                   battery_at_setpoint, input_over_limit}),
        .pin_out (cmp_s)
    );

    assign {ac_ok, pfail_cmp, pack_cmp, battery_sense_input_low_cmp, battery_sense_input_ok_cmp, vdd_low,
            at_setpoint, over_limit} = cmp_s;

    ////////////////////////////////////////////////////////////////////////////
    // stored setpoints
    logic [15:0] voltage_set;        // saturated voltage request, mV
    logic [15:0] charge_current_set; // saturated current request, mA
    logic [15:0] input_limit_set;    // saturated input limit, mA
    logic [15:0] next_voltage_set;
    logic [15:0] next_charge_current_set;
    logic [15:0] next_input_limit_set;

    // decode only whole acknowledged words; the bus engine pulses cmd_write
    // after the last acknowledge, so half-received words never land here
    always_comb begin
        next_voltage_set        = voltage_set;
        next_charge_current_set = charge_current_set;
        next_input_limit_set    = input_limit_set;
        if (vdd_low) begin
            // supply undervoltage: back to power-on values, writes ignored
            next_voltage_set        = CHGSP_V_RESET;
            next_charge_current_set = CHGSP_I_RESET;
            next_input_limit_set    = CHGSP_LIM_RESET;
        end else if (cmd_write) begin
            unique case (cmd_code)
                CHGSP_CMD_VOLTAGE: begin
                    // word is millivolts; sub-floor requests stop charging
                    if (cmd_data < CHGSP_V_MIN_MV) begin
                        next_voltage_set = '0;
                    end else begin
                        next_voltage_set = clamp16(cmd_data, CHGSP_V_MIN_MV,
                                                   CHGSP_V_MAX_MV);
                    end
                end
                CHGSP_CMD_CURRENT: begin
                    // zero really means zero; small nonzero is lifted
                    if (cmd_data == 16'h0000) begin
                        next_charge_current_set = '0;
                    end else begin
                        next_charge_current_set = clamp16(cmd_data, CHGSP_I_MIN_MA,
                                                          CHGSP_I_MAX_MA);
                    end
                end
                CHGSP_CMD_INPUT: begin
                    // the limit has no off state: zero is lifted as well
                    next_input_limit_set = clamp16(cmd_data, CHGSP_LIM_MIN_MA,
                                                   CHGSP_LIM_MAX_MA);
                end
                default: begin
                    // other charger commands belong to other blocks
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            voltage_set        <= CHGSP_V_RESET;
            charge_current_set <= CHGSP_I_RESET;
            input_limit_set    <= CHGSP_LIM_RESET;
        end else begin
            voltage_set        <= next_voltage_set;
            charge_current_set <= next_charge_current_set;
            input_limit_set    <= next_input_limit_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // battery undervoltage with hysteresis and input-limit throttle
    logic       battery_sense_input_low;        // precharge cap active
    logic [5:0] throttle;        // highest current code the input limit allows
    logic [9:0] ramp_count;      // divider for the throttle step
    logic       next_battery_sense_input_low;
    logic [5:0] next_throttle;
    logic [9:0] next_ramp_count;
    logic       ramp_tick;

    // hysteresis keeps the cap from chattering between 2.5 V and 2.7 V
    always_comb begin
        ramp_tick       = (ramp_count == CHGSP_RAMP_LAST);
        next_ramp_count = ramp_tick ? 10'h000 : ramp_count + 10'h001;
        next_battery_sense_input_low   = battery_sense_input_low;
        if (battery_sense_input_low_cmp) begin
            next_battery_sense_input_low = 1'b1;
        end else if (battery_sense_input_ok_cmp) begin
            next_battery_sense_input_low = 1'b0;
        end
        // slow ramp: the analog input loop is the fast path, this only
        // bounds the digital setpoint so the pair cannot fight
        next_throttle = throttle;
        if (vdd_low) begin
            next_throttle = CHGSP_THROTTLE_FULL;
        end else if (ramp_tick && over_limit && throttle != 6'h00) begin
            next_throttle = throttle - 6'h01;
        end else if (ramp_tick && !over_limit && throttle != CHGSP_THROTTLE_FULL) begin
            next_throttle = throttle + 6'h01;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            battery_sense_input_low   <= 1'b0;
            throttle   <= CHGSP_THROTTLE_FULL;
            ramp_count <= 10'h000;
        end else begin
            battery_sense_input_low   <= next_battery_sense_input_low;
            throttle   <= next_throttle;
            ramp_count <= next_ramp_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // effective setpoints, loop ownership, switches and flags
    logic [15:0] v_eff;          // voltage after the pin ceiling
    logic [15:0] i_eff;          // current after ceiling and precharge cap
    logic [5:0]  i_code;         // current dac code before throttling
    logic        power_fail;     // adapter too close to the battery
    logic        allow_charge;   // adapter good and supply healthy
    logic [10:0] next_voltage_dac;
    logic [5:0]  next_charge_current_dac;
    logic [5:0]  next_input_limit_dac;
    chgsp_loop_t next_active_loop;
    logic        next_charge_enable;
    logic        next_source_switch_drive;
    logic        next_load_switch_drive;
    logic [15:0] next_flags;

    always_comb begin
        power_fail   = pfail_cmp;
        allow_charge = ac_ok && !power_fail && !vdd_low;
        v_eff  = ceil_cap(voltage_set, vceil_s);
        i_eff  = ceil_cap(charge_current_set, iceil_s);
        if (battery_sense_input_low && i_eff > CHGSP_PRECHG_MA) begin
            i_eff = CHGSP_PRECHG_MA;
        end
        i_code = cur_field(i_eff);
        next_voltage_dac        = allow_charge ? v_eff[CHGSP_V_MSB:CHGSP_V_LSB] : '0;
        next_charge_current_dac = (!allow_charge) ? 6'h00 :
                                  (i_code > throttle) ? throttle : i_code;
        next_input_limit_dac    = cur_field(input_limit_set);
        next_charge_enable      = allow_charge && voltage_set != 16'h0000;
        // input overload hands over to the input loop; otherwise the current loop charges until the battery reaches its setpoint
        if (!next_charge_enable) begin
            next_active_loop = CHGSP_LOOP_OFF;
        end else if (over_limit) begin
            next_active_loop = CHGSP_LOOP_INPUT;
        end else if (at_setpoint) begin
            next_active_loop = CHGSP_LOOP_VOLTAGE;
        end else begin
            next_active_loop = CHGSP_LOOP_CURRENT;
        end
        // source switch on with a good adapter, load switch on without one
        next_source_switch_drive = ac_ok && !power_fail;
        next_load_switch_drive   = !next_source_switch_drive;
        next_flags                     = 16'h0000;
        next_flags[CHGSP_FLAG_ADAPTER] = ac_ok;
        next_flags[CHGSP_FLAG_PACK]    = pack_cmp;
        next_flags[CHGSP_FLAG_SUPFAIL] = power_fail;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            voltage_dac         <= '0;
            charge_current_dac  <= '0;
            input_limit_dac     <= '0;
            active_loop         <= CHGSP_LOOP_OFF;
            charge_enable       <= 1'b0;
            source_switch_drive <= 1'b0;
            load_switch_drive   <= 1'b1;
            charger_flags_word  <= 16'h0000;
        end else begin
            voltage_dac         <= next_voltage_dac;
            charge_current_dac  <= next_charge_current_dac;
            input_limit_dac     <= next_input_limit_dac;
            active_loop         <= next_active_loop;
            charge_enable       <= next_charge_enable;
            source_switch_drive <= next_source_switch_drive;
            load_switch_drive   <= next_load_switch_drive;
            charger_flags_word  <= next_flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_volt_sat_write: assert property (
        cmd_write && cmd_code == CHGSP_CMD_VOLTAGE && cmd_data > CHGSP_V_MAX_MV && !vdd_low
        |=> voltage_set == CHGSP_V_MAX_MV)
        else $error("voltage request not saturated");
    a_volt_floor_zero: assert property (
        cmd_write && cmd_code == CHGSP_CMD_VOLTAGE && cmd_data < CHGSP_V_MIN_MV && !vdd_low
        |-> ##2 voltage_dac == 11'h000)
        else $error("low voltage request did not zero dac");
    a_cur_floor_lift: assert property (
        cmd_write && cmd_code == CHGSP_CMD_CURRENT && cmd_data != 16'h0000
        && cmd_data <= CHGSP_I_MIN_MA && !vdd_low |=> charge_current_set == CHGSP_I_MIN_MA)
        else $error("small current request not lifted");
    a_lim_sat_write: assert property (
        cmd_write && cmd_code == CHGSP_CMD_INPUT && cmd_data > CHGSP_LIM_MAX_MA && !vdd_low
        |=> input_limit_set == CHGSP_LIM_MAX_MA)
        else $error("input limit not saturated");
    a_lim_floor_lift: assert property (
        cmd_write && cmd_code == CHGSP_CMD_INPUT && cmd_data <= CHGSP_LIM_MIN_MA && !vdd_low
        |=> input_limit_set == CHGSP_LIM_MIN_MA)
        else $error("small input limit not lifted");
    a_vdd_low_reset: assert property (
        vdd_low |=> charge_current_set == CHGSP_I_RESET && input_limit_set == CHGSP_LIM_RESET
        && voltage_set == CHGSP_V_RESET ##1 !charge_enable)
        else $error("supply undervoltage did not restore reset state");
    a_battery_sense_input_low_cap: assert property (
        battery_sense_input_low |=> charge_current_dac <= 6'h01)
        else $error("precharge cap exceeded");
    a_pfail_source: assert property (
        charger_flags_word[CHGSP_FLAG_SUPFAIL] |-> !source_switch_drive && load_switch_drive)
        else $error("source switch closed in power fail");
    a_throttle_step: assert property (
        ramp_tick && over_limit && !vdd_low && throttle != 6'h00
        |=> throttle == $past(throttle) - 6'h01)
        else $error("throttle did not step down");
    a_loop_voltage: assert property (
        next_charge_enable && !over_limit && at_setpoint |=> active_loop == CHGSP_LOOP_VOLTAGE)
        else $error("voltage loop not selected at setpoint");

    c_volt_write: cover property (cmd_write && cmd_code == CHGSP_CMD_VOLTAGE);
    c_loop_handover: cover property (active_loop == CHGSP_LOOP_CURRENT
                                     ##1 active_loop == CHGSP_LOOP_VOLTAGE);
    c_power_fail: cover property (charger_flags_word[CHGSP_FLAG_SUPFAIL]);
    c_throttle_zero: cover property (throttle == 6'h00);

endmodule
`default_nettype wire

// ===== tb/chgsp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host on the management bus: hands over whole acknowledged words only
module chgsp_host_model (
    input  wire logic        clock,
    output var  logic [7:0]  cmd_code,
    output var  logic [15:0] cmd_data,
    output var  logic        cmd_write
);
    initial begin
        cmd_code  = 8'h00;
        cmd_data  = 16'h0000;
        cmd_write = 1'b0;
    end
    // single-cycle strobe; the word is scrambled once released so stale data never counts
    task automatic write_word(input logic [7:0] code, input logic [15:0] data);
        @(posedge clock);
        cmd_code  <= code;
        cmd_data  <= data;
        cmd_write <= 1'b1;
        @(posedge clock);
        cmd_write <= 1'b0;
        cmd_data  <= ~data;
    endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import chgsp_pkg::*;
;
    logic clock, rst, cw, amin, abat, thermistor_input, blow, bres, slow, bset, iover;
    logic [7:0]  cc;
    logic [15:0] cd, flags;
    logic [11:0] vpin, ipin;
    logic [10:0] vdac;
    logic [5:0]  idac, ldac;
    chgsp_loop_t loop_s;
    logic        en, src, ld;
    int          bad_count, num_checks, cycles;
    // whole-word table: command, data, expected dac code
    localparam logic [7:0]  TC[12] = '{8'h15, 8'h15, 8'h15, 8'h15, 8'h14, 8'h14,
                                       8'h14, 8'h14, 8'h3f, 8'h3f, 8'h3f, 8'h3f};
    localparam logic [15:0] TD[12] = '{16'h2ee0, 16'h03ff, 16'hffff, 16'h0400,
        16'h0001, 16'hffff, 16'h0000, 16'h0fff, 16'h0000, 16'hffff, 16'h0100, 16'h0fff};
    localparam logic [15:0] TE[12] = '{16'h02ee, 16'h0000, 16'h04b0, 16'h0040,
        16'h0001, 16'h003f, 16'h0000, 16'h001f, 16'h0002, 16'h003f, 16'h0002, 16'h001f};
    chgsp_host_model chgsp_host_model_i (.clock(clock), .cmd_code(cc), .cmd_data(cd),
        .cmd_write(cw));
    chgsp_decoder chgsp_decoder_i (.clock(clock), .rst(rst), .cmd_code(cc), .cmd_data(cd),
        .cmd_write(cw), .voltage_ceiling_pin(vpin), .current_ceiling_pin(ipin),
        .adapter_above_min(amin), .adapter_below_battery(abat),
        .thermistor_input_low(thermistor_input), .battery_below_low(blow),
        .battery_above_resume(bres), .logic_supply_low(slow),
        .battery_at_setpoint(bset), .input_over_limit(iover), .voltage_dac(vdac),
        .charge_current_dac(idac), .input_limit_dac(ldac), .active_loop(loop_s),
        .charge_enable(en), .source_switch_drive(src), .load_switch_drive(ld),
        .charger_flags_word(flags));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // hang guard; the overload ramp down and back up alone spans about 48500 edges
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            complete_run();
        end
    end
    task automatic complete_run();
        if (bad_count == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // pins pass a synchroniser, so allow eight edges before looking
    task automatic settle();
        repeat (8) @(posedge clock);
        #1;
    endtask
    task automatic t_table();
        for (int i = 0; i < 12; i++) begin
            chgsp_host_model_i.write_word(TC[i], TD[i]);
            settle();
            check("dac", (TC[i] == 8'h15) ? 16'(vdac) : (TC[i] == 8'h14) ? 16'(idac)
                : 16'(ldac), TE[i]);
        end
    endtask
    task automatic t_ceil();
        @(posedge clock);
        vpin <= 12'h3e8;
        ipin <= 12'h064;
        chgsp_host_model_i.write_word(8'h15, 16'h2ee0);
        settle();
        check("vceil", 16'(vdac), 16'h0138);
        check("iceil", 16'(idac), 16'h0003);
        @(posedge clock);
        vpin <= 12'hfff;
        ipin <= 12'hfff;
    endtask
    task automatic t_states();
        @(posedge clock);
        thermistor_input  <= 1'b1;
        abat <= 1'b1;
        settle();
        check("flags", flags, 16'he000);
        check("switch", 16'({src, ld}), 16'h0001);
        check("pf_en", 16'(en), 16'h0000);
        @(posedge clock);
        abat <= 1'b0;
        bset <= 1'b1;
        blow <= 1'b1;
        bres <= 1'b0;
        settle();
        check("loop", 16'(loop_s), 16'(CHGSP_LOOP_VOLTAGE));
        check("prechg", 16'(idac), 16'h0001);
        check("en", 16'(en), 16'h0001);
        @(posedge clock);
        bset <= 1'b0;
        blow <= 1'b0;
        bres <= 1'b1;
        iover <= 1'b1;
        // 64 ramp steps: enough to walk the throttle from full scale down to zero
        repeat (32000) @(posedge clock);
        settle();
        check("loop", 16'(loop_s), 16'(CHGSP_LOOP_INPUT));
        check("throttled", 16'(idac), 16'h0000);
        @(posedge clock);
        iover <= 1'b0;
        // 33 ramp steps back up lift the throttle above the code of 31
        repeat (16500) @(posedge clock);
        settle();
        check("loop", 16'(loop_s), 16'(CHGSP_LOOP_CURRENT));
        check("resume", 16'(idac), 16'h001f);
    endtask
    task automatic t_supply();
        @(posedge clock);
        slow <= 1'b1;
        settle();
        check("vlow", 16'(vdac), 16'h0000);
        check("vlow_en", 16'(en), 16'h0000);
        chgsp_host_model_i.write_word(8'h3f, 16'hffff);
        slow <= 1'b0;
        settle();
        check("por", 16'(ldac), 16'h0002);
        check("por", 16'(idac), 16'h0001);
        check("por_en", 16'(en), 16'h0000);
    endtask
    initial begin
        {rst, amin, bres} = 3'b111;
        {abat, thermistor_input, blow, slow, bset, iover} = 6'h00;
        {vpin, ipin} = {12'hfff, 12'hfff};
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        settle();
        check("lim0", 16'(ldac), 16'h0002);
        check("cur0", 16'(idac), 16'h0001);
        t_table();
        t_ceil();
        t_states();
        t_supply();
        complete_run();
    end
endmodule
`default_nettype wire
